// ==== flash_program_op_control.sv ====
// Flash program and erase sequencer with operation code lock and data buffers.
`timescale 1ns/1ps
module flash_program_op_control (
  input  wire logic                           mclk,
  input  wire logic                           rstn,
  input  wire logic                           write_unlock_enable,
  input  wire logic                           op_wr,
  input  wire logic [fpc_pkg::OP_W-1:0]       op_wdata,
  output logic [fpc_pkg::OP_W-1:0]            flash_op_code,
  input  wire logic                           data_wr,
  input  wire logic [fpc_pkg::DATA_IDX_W-1:0] data_idx,
  input  wire logic [fpc_pkg::DATA_W-1:0]     data_wdata,
  input  wire logic                           row_wr,
  input  wire logic [fpc_pkg::ROW_IDX_W-1:0]  row_idx,
  input  wire logic [fpc_pkg::DATA_W-1:0]     row_wdata,
  input  wire fpc_pkg::fpc_addr_t             target_addr,
  input  wire logic                           start,
  output logic                                busy,
  output logic                                done,
  output logic                                op_error,
  output logic                                arr_valid,
  output logic [fpc_pkg::KIND_W-1:0]          arr_kind,
  output fpc_pkg::fpc_addr_t                  arr_addr,
  output logic [fpc_pkg::DATA_W-1:0]          arr_wdata,
  input  wire logic                           arr_done
);
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_ISSUE = 1'b1
  } fpc_state_e;

  fpc_state_e                   state_reg;
  logic [fpc_pkg::OP_W-1:0]     op_reg;
  logic [fpc_pkg::DATA_W-1:0]   data_word_reg [4];
  logic [fpc_pkg::DATA_W-1:0]   row_buf [fpc_pkg::ROW_WORDS];
  fpc_pkg::fpc_cnt_t            cnt_reg;
  fpc_pkg::fpc_cnt_t            total_reg;
  fpc_pkg::fpc_addr_t           base_reg;
  logic [fpc_pkg::KIND_W-1:0]   kind_reg;
  logic                         launch;
  logic                         last_word;
  logic [fpc_pkg::DATA_W-1:0]   word_data;

  fpc_flash_if fl ();

  fpc_array_port u_port (
    .mclk      (mclk),
    .rstn      (rstn),
    .fl        (fl.port),
    .arr_valid (arr_valid),
    .arr_kind  (arr_kind),
    .arr_addr  (arr_addr),
    .arr_wdata (arr_wdata),
    .arr_done  (arr_done)
  );

  assign busy          = (state_reg == ST_ISSUE);
  assign flash_op_code = op_reg;
  assign launch        = start && (state_reg == ST_IDLE);
  assign last_word     = (cnt_reg == (total_reg - fpc_pkg::CNT_ONE));

  // Writes are ignored while busy so a running sequence never changes under itself.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      op_reg <= fpc_pkg::OP_RESET_VAL;
    end
    else if (op_wr && write_unlock_enable && !busy)
    begin
      op_reg <= op_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        data_word_reg[i] <= fpc_pkg::DATA_ZERO;
      end
    end
    else if (data_wr && !busy)
    begin
      data_word_reg[data_idx] <= data_wdata;
    end
  end

  // The row buffer has no reset; software fills all 512 words before a row program.
  always_ff @(posedge mclk)
  begin
    if (row_wr && !busy)
    begin
      row_buf[row_idx] <= row_wdata;
    end
  end

  always_comb
  begin
    case (op_reg)
      fpc_pkg::OP_ROW_PROG:  word_data = row_buf[cnt_reg[fpc_pkg::ROW_IDX_W-1:0]];
      fpc_pkg::OP_QUAD_PROG: word_data = data_word_reg[cnt_reg[1:0]];
      default:               word_data = data_word_reg[0];
    endcase
  end

  // Word k of a burst goes to base plus 4k, so data word 0 takes the lowest address.
  assign fl.req  = busy;
  assign fl.kind = kind_reg;
  assign fl.addr = base_reg + fpc_pkg::fpc_addr_t'({cnt_reg, 2'b00});
  assign fl.data = word_data;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      total_reg <= fpc_pkg::CNT_ONE;
      base_reg  <= fpc_pkg::ADDR_ZERO;
      kind_reg  <= fpc_pkg::KIND_PROG;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          cnt_reg <= '0;
          if (launch)
          begin
            case (op_reg)
              fpc_pkg::OP_WORD_PROG:
              begin
                state_reg <= ST_ISSUE;
                total_reg <= fpc_pkg::CNT_ONE;
                base_reg  <= target_addr & fpc_pkg::WORD_MASK;
                kind_reg  <= fpc_pkg::KIND_PROG;
              end
              fpc_pkg::OP_QUAD_PROG:
              begin
                state_reg <= ST_ISSUE;
                total_reg <= fpc_pkg::QUAD_WORDS;
                base_reg  <= target_addr & fpc_pkg::QUAD_MASK;
                kind_reg  <= fpc_pkg::KIND_PROG;
              end
              fpc_pkg::OP_ROW_PROG:
              begin
                state_reg <= ST_ISSUE;
                total_reg <= fpc_pkg::ROW_WORDS;
                base_reg  <= target_addr & fpc_pkg::ROW_MASK;
                kind_reg  <= fpc_pkg::KIND_PROG;
              end
              fpc_pkg::OP_PAGE_ERASE:
              begin
                state_reg <= ST_ISSUE;
                total_reg <= fpc_pkg::CNT_ONE;
                base_reg  <= target_addr & fpc_pkg::PAGE_MASK;
                kind_reg  <= fpc_pkg::KIND_ERASE_PAGE;
              end
              fpc_pkg::OP_LOWER_ERASE:
              begin
                state_reg <= ST_ISSUE;
                total_reg <= fpc_pkg::CNT_ONE;
                base_reg  <= fpc_pkg::ADDR_ZERO;
                kind_reg  <= fpc_pkg::KIND_ERASE_LOWER;
              end
              fpc_pkg::OP_UPPER_ERASE:
              begin
                state_reg <= ST_ISSUE;
                total_reg <= fpc_pkg::CNT_ONE;
                base_reg  <= fpc_pkg::ADDR_ZERO;
                kind_reg  <= fpc_pkg::KIND_ERASE_UPPER;
              end
              fpc_pkg::OP_ALL_ERASE:
              begin
                state_reg <= ST_ISSUE;
                total_reg <= fpc_pkg::CNT_ONE;
                base_reg  <= fpc_pkg::ADDR_ZERO;
                kind_reg  <= fpc_pkg::KIND_ERASE_ALL;
              end
              default:
              begin
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ISSUE:
        begin
          if (fl.ack)
          begin
            if (last_word)
            begin
              state_reg <= ST_IDLE;
            end
            else
            begin
              cnt_reg <= cnt_reg + fpc_pkg::CNT_ONE;
            end
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // A no-op or reserved code finishes at once; reserved codes also raise the error flag.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      done     <= 1'b0;
      op_error <= 1'b0;
    end
    else
    begin
      done <= (launch && (op_reg == fpc_pkg::OP_NOP || op_reg > fpc_pkg::OP_ALL_ERASE))
              || (busy && fl.ack && last_word);
      if (launch)
      begin
        op_error <= (op_reg > fpc_pkg::OP_ALL_ERASE);
      end
    end
  end

  fpc_pkg::fpc_cnt_t ack_cnt;

  always_ff @(posedge mclk)
  begin
    if (!rstn || launch)
    begin
      ack_cnt <= '0;
    end
    else if (fl.ack)
    begin
      ack_cnt <= ack_cnt + fpc_pkg::CNT_ONE;
    end
  end

  op_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
    op_wr && !write_unlock_enable |=> $stable(flash_op_code))
    else $error("operation code changed without unlock");

  op_load_a: assert property (@(posedge mclk) disable iff (!rstn)
    op_wr && write_unlock_enable && !busy |=> flash_op_code == $past(op_wdata))
    else $error("unlocked operation code write lost");

  nop_done_a: assert property (@(posedge mclk) disable iff (!rstn)
    launch && op_reg == fpc_pkg::OP_NOP |=> done && !busy && !op_error ##1 !arr_valid)
    else $error("no-op did not finish cleanly");

  reserved_op_a: assert property (@(posedge mclk) disable iff (!rstn)
    launch && op_reg[3] |=> op_error && done && !busy)
    else $error("reserved code not flagged");

  row_count_a: assert property (@(posedge mclk) disable iff (!rstn)
    done && op_reg == fpc_pkg::OP_ROW_PROG |-> ack_cnt == fpc_pkg::ROW_WORDS)
    else $error("row program did not write 512 words");

  quad_count_a: assert property (@(posedge mclk) disable iff (!rstn)
    done && op_reg == fpc_pkg::OP_QUAD_PROG |-> ack_cnt == fpc_pkg::QUAD_WORDS)
    else $error("quad program did not write four words");

  page_align_a: assert property (@(posedge mclk) disable iff (!rstn)
    arr_valid && arr_kind == fpc_pkg::KIND_ERASE_PAGE
    |-> (arr_addr & ~fpc_pkg::PAGE_MASK) == fpc_pkg::ADDR_ZERO)
    else $error("page erase address not on 16 KB boundary");

  quad_order_a: assert property (@(posedge mclk) disable iff (!rstn)
    busy && fl.ack && !last_word && op_reg == fpc_pkg::OP_QUAD_PROG
    |=> fl.addr == $past(fl.addr) + 24'h000004 && fl.data == data_word_reg[fl.addr[3:2]])
    else $error("quad words out of ascending order");

  // The data word is tied to the address the array sees, not to the internal counter.
  quad_data_a: assert property (@(posedge mclk) disable iff (!rstn)
    arr_valid && arr_kind == fpc_pkg::KIND_PROG && op_reg == fpc_pkg::OP_QUAD_PROG
    |-> arr_wdata == data_word_reg[arr_addr[3:2]])
    else $error("quad data word not at its address");

  quad_prog_c: cover property (@(posedge mclk) disable iff (!rstn)
    done && op_reg == fpc_pkg::OP_QUAD_PROG);
  row_prog_c: cover property (@(posedge mclk) disable iff (!rstn)
    done && op_reg == fpc_pkg::OP_ROW_PROG);
  page_erase_c: cover property (@(posedge mclk) disable iff (!rstn)
    done && op_reg == fpc_pkg::OP_PAGE_ERASE);
  locked_write_c: cover property (@(posedge mclk) disable iff (!rstn)
    op_wr && !write_unlock_enable);
endmodule

// ==== fpc_pkg.sv ====
// Constants and types shared by the flash program and erase sequencer.
// Summary of operation
// - Codes 0000-0011: none, word, quad, row program.
// - Codes 0100-0111 erase; codes 1000-1111 are reserved.
// - Row program writes 512 words, 2 KB.
// - Page erase clears aligned 16 KB page.
// - Operation code writes need write unlock enable set.
// - Four addressable 32-bit data words feed quad program.
package fpc_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int OP_W   = 4;
  localparam int KIND_W = 3;
  localparam int CNT_W  = 10;
  localparam int ROW_IDX_W  = 9;
  localparam int DATA_IDX_W = 2;

  typedef logic [ADDR_W-1:0] fpc_addr_t;
  typedef logic [CNT_W-1:0]  fpc_cnt_t;

  localparam logic [OP_W-1:0] OP_NOP         = 4'h0;
  localparam logic [OP_W-1:0] OP_WORD_PROG   = 4'h1;
  localparam logic [OP_W-1:0] OP_QUAD_PROG   = 4'h2;
  localparam logic [OP_W-1:0] OP_ROW_PROG    = 4'h3;
  localparam logic [OP_W-1:0] OP_PAGE_ERASE  = 4'h4;
  localparam logic [OP_W-1:0] OP_LOWER_ERASE = 4'h5;
  localparam logic [OP_W-1:0] OP_UPPER_ERASE = 4'h6;
  localparam logic [OP_W-1:0] OP_ALL_ERASE   = 4'h7;
  localparam logic [OP_W-1:0] OP_RESET_VAL   = 4'h0;

  localparam logic [KIND_W-1:0] KIND_PROG        = 3'h0;
  localparam logic [KIND_W-1:0] KIND_ERASE_PAGE  = 3'h1;
  localparam logic [KIND_W-1:0] KIND_ERASE_LOWER = 3'h2;
  localparam logic [KIND_W-1:0] KIND_ERASE_UPPER = 3'h3;
  localparam logic [KIND_W-1:0] KIND_ERASE_ALL   = 3'h4;

  localparam fpc_cnt_t CNT_ONE    = 10'h001;
  localparam fpc_cnt_t QUAD_WORDS = 10'h004;
  localparam fpc_cnt_t ROW_WORDS  = 10'h200;

  localparam fpc_addr_t WORD_MASK = 24'hfffffc;
  localparam fpc_addr_t QUAD_MASK = 24'hfffff0;
  localparam fpc_addr_t ROW_MASK  = 24'hfff800;
  localparam fpc_addr_t PAGE_MASK = 24'hffc000;
  localparam fpc_addr_t ADDR_ZERO = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
endpackage

// ==== fpc_flash_if.sv ====
// Word request channel between the sequencer and the array port.
`timescale 1ns/1ps
interface fpc_flash_if;
  logic                              req;
  logic                              ack;
  logic [fpc_pkg::KIND_W-1:0]        kind;
  fpc_pkg::fpc_addr_t                addr;
  logic [fpc_pkg::DATA_W-1:0]        data;

  modport seq  (output req, output kind, output addr, output data, input ack);
  modport port (input req, input kind, input addr, input data, output ack);
endinterface

// ==== fpc_array_port.sv ====
// Array-side port that holds one command until the flash array finishes it.
`timescale 1ns/1ps
module fpc_array_port (
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  fpc_flash_if.port                       fl,
  output logic                            arr_valid,
  output logic [fpc_pkg::KIND_W-1:0]      arr_kind,
  output fpc_pkg::fpc_addr_t              arr_addr,
  output logic [fpc_pkg::DATA_W-1:0]      arr_wdata,
  input  wire logic                       arr_done
);
  logic busy_reg;

  // The ack is combinational so the sequencer advances before a stale request is re-taken.
  assign fl.ack    = busy_reg && arr_done;
  assign arr_valid = busy_reg;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      busy_reg  <= 1'b0;
      arr_kind  <= fpc_pkg::KIND_PROG;
      arr_addr  <= fpc_pkg::ADDR_ZERO;
      arr_wdata <= fpc_pkg::DATA_ZERO;
    end
    else if (!busy_reg && fl.req)
    begin
      busy_reg  <= 1'b1;
      arr_kind  <= fl.kind;
      arr_addr  <= fl.addr;
      arr_wdata <= fl.data;
    end
    else if (busy_reg && arr_done)
    begin
      busy_reg <= 1'b0;
    end
  end

  cmd_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    arr_valid && !arr_done |=> arr_valid && $stable(arr_addr) && $stable(arr_wdata))
    else $error("array command changed before completion");
endmodule

// ==== fpc_array_model.sv ====
// Behavioural model of the program flash array that answers each pending command.
`timescale 1ns/1ps
module fpc_array_model (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic slow,
  input  wire logic arr_valid,
  output logic      arr_done
);
  logic [1:0] wait_reg;
  logic [1:0] lim_reg;

  // Completion is a single pulse, and never repeats in the cycle the command is withdrawn.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      arr_done <= 1'b0;
      wait_reg <= 2'h0;
      lim_reg  <= 2'h0;
    end
    else if (arr_valid && !arr_done && wait_reg == lim_reg)
    begin
      arr_done <= 1'b1;
      wait_reg <= 2'h0;
      lim_reg  <= slow ? 2'($urandom_range(1, 3)) : 2'h0;
    end
    else
    begin
      arr_done <= 1'b0;
      if (arr_valid && !arr_done)
        wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

// ==== test_flash_program_op_control.sv ====
// Self-checking testbench for the flash program and erase sequencer.
`timescale 1ns/1ps
module test_flash_program_op_control;
  logic                              mclk = 1'b0;
  logic                              rstn, write_unlock_enable, op_wr, data_wr, row_wr, start;
  logic                              slow, busy, done, op_error, arr_valid, arr_done;
  logic [fpc_pkg::OP_W-1:0]          op_wdata, flash_op_code;
  logic [1:0]                        data_idx;
  logic [8:0]                        row_idx;
  logic [31:0]                       data_wdata, row_wdata, arr_wdata;
  logic [fpc_pkg::KIND_W-1:0]        arr_kind;
  fpc_pkg::fpc_addr_t                target_addr, arr_addr;
  logic [31:0]                       row_mem[512];
  logic [31:0]                       dw[4];
  logic [31:0]                       q_kind[$], q_addr[$], q_data[$];
  int                                miscompares, num_checks, cycles;

  flash_program_op_control flash_program_op_control_i (.mclk(mclk), .rstn(rstn),
    .write_unlock_enable(write_unlock_enable), .op_wr(op_wr), .op_wdata(op_wdata),
    .flash_op_code(flash_op_code), .data_wr(data_wr), .data_idx(data_idx),
    .data_wdata(data_wdata), .row_wr(row_wr), .row_idx(row_idx), .row_wdata(row_wdata),
    .target_addr(target_addr), .start(start), .busy(busy), .done(done),
    .op_error(op_error), .arr_valid(arr_valid), .arr_kind(arr_kind), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_done(arr_done));
  fpc_array_model fpc_array_model_i (.mclk(mclk), .rstn(rstn), .slow(slow),
    .arr_valid(arr_valid), .arr_done(arr_done));

  always #20 mclk = ~mclk;

  always @(posedge mclk)
  begin
    if (rstn && arr_valid && arr_done)
    begin
      q_kind.push_back(32'(arr_kind));
      q_addr.push_back(32'(arr_addr));
      q_data.push_back(arr_wdata);
    end
  end

  // A hang is cut short well above the longest expected run.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int exp_count(input int code);
    if (code == 2)
      return 4;
    if (code == 3)
      return 512;
    return (code >= 1 && code <= 7) ? 1 : 0;
  endfunction

  function automatic logic [31:0] exp_addr(input int code, input logic [23:0] a, input int k);
    case (code)
      1: return 32'(a & 24'hfffffc);
      2: return 32'((a & 24'hfffff0) + 24'(4 * k));
      3: return 32'((a & 24'hfff800) + 24'(4 * k));
      4: return 32'(a & 24'hffc000);
      default: return 32'h00000000;
    endcase
  endfunction

  task automatic write_op(input logic [3:0] code, input logic unlock);
    logic [3:0] prev;
    prev = flash_op_code;
    @(negedge mclk);
    op_wr = 1'b1;
    op_wdata = code;
    write_unlock_enable = unlock;
    @(negedge mclk);
    op_wr = 1'b0;
    check(32'(flash_op_code), 32'(unlock ? code : prev));
  endtask

  task automatic run(input int code, input logic [23:0] a);
    int w;
    int n;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      data_wr = 1'b1;
      data_idx = 2'(i);
      data_wdata = $urandom;
      dw[i] = data_wdata;
    end
    @(negedge mclk);
    data_wr = 1'b0;
    write_op(~4'(code), 1'b0);
    write_op(4'(code), 1'b1);
    slow = 1'($urandom_range(0, 1));
    q_kind.delete();
    q_addr.delete();
    q_data.delete();
    target_addr = a;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    // Writes and a second launch while busy must leave the running operation untouched.
    for (w = 0; w < 5000 && done !== 1'b1; w++)
    begin
      @(negedge mclk);
      data_wr = (w == 1 && busy === 1'b1);
      start = data_wr;
      row_wr = data_wr;
      op_wr = data_wr;
      data_idx = 2'h3;
      data_wdata = ~dw[3];
      row_idx = 9'h1ff;
      row_wdata = ~row_mem[511];
      op_wdata = ~4'(code);
    end
    data_wr = 1'b0;
    start = 1'b0;
    row_wr = 1'b0;
    op_wr = 1'b0;
    n = exp_count(code);
    check(32'(done), 32'h1);
    check(32'(flash_op_code), 32'(code));
    check(32'(op_error), 32'(code >= 8));
    check(32'(q_kind.size()), 32'(n));
    for (int k = 0; k < n && k < q_kind.size(); k++)
    begin
      check(q_kind[k], (code <= 3) ? 32'h0 : 32'(code - 3));
      check(q_addr[k], exp_addr(code, a, k));
      if (code == 1 || code == 2)
        check(q_data[k], dw[k]);
      if (code == 3)
        check(q_data[k], row_mem[k]);
    end
  endtask

  initial
  begin
    {rstn, write_unlock_enable, op_wr, data_wr, row_wr, start, slow} = 7'h00;
    {op_wdata, data_idx, row_idx, data_wdata, row_wdata, target_addr} = '0;
    void'($urandom(32'h14cc));
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    check(32'({flash_op_code, busy, done, op_error, arr_valid}), 32'h0);
    for (int i = 0; i < 512; i++)
    begin
      @(negedge mclk);
      row_wr = 1'b1;
      row_idx = 9'(i);
      row_wdata = $urandom;
      row_mem[i] = row_wdata;
    end
    @(negedge mclk);
    row_wr = 1'b0;
    for (int c = 0; c < 16; c++)
      run(c, 24'($urandom));
    // Unaligned addresses for quad program, row program and page erase.
    run(2, 24'hfffffc);
    run(3, 24'h0007fc);
    run(4, 24'h003fff);
    repeat (6) run($urandom_range(0, 15), 24'($urandom));
    conclude();
  end
endmodule
